// ---- hw/sfd_pkg.sv ----
// constants for the special-function command decoder of a multichannel converter
// assumes a 24-bit serial word, mode bits on top, function code below them
package sfd_pkg;

	// ------------------------------------------------------------
	// serial word layout
	// ------------------------------------------------------------
	localparam int          WORD_BITS    = 24;
	localparam int          MODE_LSB     = 22;
	localparam int          FUNC_LSB     = 16;
	localparam int          FUNC_W       = 6;
	localparam int          OPND_W       = 16;
	localparam logic [1:0]  MODE_SPECIAL = 2'h0;
	localparam logic [4:0]  FRAME_BITS   = 5'h18;
	localparam logic [4:0]  CNT_OVER     = 5'h19;

	// ------------------------------------------------------------
	// function codes
	// ------------------------------------------------------------
	localparam logic [5:0]  FN_NOP       = 6'h00;
	localparam logic [5:0]  FN_CONTROL   = 6'h01;
	localparam logic [5:0]  FN_OFS_ZERO  = 6'h02;
	localparam logic [5:0]  FN_OFS_ONE   = 6'h03;
	localparam logic [5:0]  FN_READ_SEL  = 6'h05;
	localparam logic [5:0]  FN_BANK_0    = 6'h06;
	localparam logic [5:0]  FN_BANK_ALL  = 6'h0b;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int          CTL_PD_BIT    = 0;
	localparam int          CTL_TSD_BIT   = 1;
	localparam int          CTL_SEL_B_BIT = 2;
	localparam int          CTL_OT_BIT    = 4;

	// ------------------------------------------------------------
	// register widths and reset values
	// ------------------------------------------------------------
	localparam int          OFS_W        = 14;
	localparam int          BANK_W       = 8;
	localparam int          BANK_COUNT   = 5;
	localparam logic [13:0] OFS_RESET    = 14'h0000;
	localparam logic [7:0]  BANK_RESET   = 8'h00;
	localparam logic        CTL_RESET    = 1'b0;

	// ------------------------------------------------------------
	// readback operand decode
	// ------------------------------------------------------------
	localparam int          RB_KIND_LSB    = 13;
	localparam int          RB_CODE_LSB    = 7;
	localparam logic [2:0]  RB_KIND_GLOBAL = 3'h4;
	localparam logic [5:0]  RB_CONTROL     = 6'h01;
	localparam logic [5:0]  RB_OFS_ZERO    = 6'h02;
	localparam logic [5:0]  RB_OFS_ONE     = 6'h03;
	localparam logic [5:0]  RB_BANK_0      = 6'h06;
	localparam logic [5:0]  RB_CHAN_FIRST  = 6'h08;
	localparam logic [5:0]  RB_CHAN_LAST   = 6'h2f;

endpackage : sfd_pkg

// ---- hw/serial_special_function_decoder.sv ----
// special-function command decoder and readback shifter of a serial converter
// assumes all serial pins are asynchronous to sys_clk and much slower than it
module serial_special_function_decoder (
	// clock and reset
	input  wire logic                                sys_clk,
	input  wire logic                                rstn,
	// serial link pins
	input  wire logic                                serial_clock,
	input  wire logic                                frame_sync_n,
	input  wire logic                                serial_data_input,
	output logic                                     serial_data_output,
	output logic                                     serial_data_output_oe,
	// status from the analog side
	input  wire logic                                overtemp_alarm,
	// per-channel readback source, same clock
	input  wire logic [15:0]                         channel_read_data,
	output logic [2:0]                               readback_kind_q,
	output logic [5:0]                               readback_channel_q,
	output logic                                     readback_channel_valid_q,
	// control register fields
	output logic                                     input_select_b_q,
	output logic                                     thermal_shutdown_en_q,
	output logic                                     power_down_q,
	// offset levels and bank selection
	output logic [sfd_pkg::OFS_W-1:0]                offset_level_zero_q,
	output logic [sfd_pkg::OFS_W-1:0]                offset_level_one_q,
	output logic [sfd_pkg::BANK_COUNT*sfd_pkg::BANK_W-1:0] channel_uses_b_q
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sclk_meta_q, sclk_q, sclk_prev_q;
	logic sync_meta_q, sync_q, sync_prev_q;
	logic sdi_meta_q, sdi_q;
	logic ot_meta_q, ot_q;

	// two flops per pin, plus a history flop on clock and sync; the first flop feeds no logic
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_meta_q <= 1'b0;
			sclk_q      <= 1'b0;
			sclk_prev_q <= 1'b0;
			sync_meta_q <= 1'b1;
			sync_q      <= 1'b1;
			sync_prev_q <= 1'b1;
			sdi_meta_q  <= 1'b0;
			sdi_q       <= 1'b0;
			ot_meta_q   <= 1'b0;
			ot_q        <= 1'b0;
		end
		else
		begin
			sclk_meta_q <= serial_clock;
			sclk_q      <= sclk_meta_q;
			sclk_prev_q <= sclk_q;
			sync_meta_q <= frame_sync_n;
			sync_q      <= sync_meta_q;
			sync_prev_q <= sync_q;
			sdi_meta_q  <= serial_data_input;
			sdi_q       <= sdi_meta_q;
			ot_meta_q   <= overtemp_alarm;
			ot_q        <= ot_meta_q;
		end
	end

	// edge events on the synchronised copies
	// a clock idling high gives one rise after reset; harmless outside a readback
	logic sclk_fall, sclk_rise, frame_start, frame_end;
	assign sclk_fall   = sclk_prev_q & ~sclk_q;
	assign sclk_rise   = ~sclk_prev_q & sclk_q;
	assign frame_start = sync_prev_q & ~sync_q;
	assign frame_end   = ~sync_prev_q & sync_q;

	// ------------------------------------------------------------
	// receive shifter
	// ------------------------------------------------------------
	logic [sfd_pkg::WORD_BITS-1:0] rx_q;
	logic [4:0]                    bit_cnt_q;

	// data sampled on falling clock; count saturates to flag overlong frames
	// every frame start restarts the count, so a cut frame is never applied
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_q      <= '0;
			bit_cnt_q <= 5'h00;
		end
		else if (frame_start)
			bit_cnt_q <= 5'h00;
		else if (!sync_q && sclk_fall)
		begin
			rx_q <= {rx_q[sfd_pkg::WORD_BITS-2:0], sdi_q};
			if (bit_cnt_q != sfd_pkg::CNT_OVER)
				bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic        word_valid, special;
	logic [5:0]  func;
	logic [15:0] opnd;

	// judged only at frame end: short or long frames drop out whole
	assign word_valid = frame_end && (bit_cnt_q == sfd_pkg::FRAME_BITS);
	assign special    = rx_q[sfd_pkg::WORD_BITS-1:sfd_pkg::MODE_LSB]
	                    == sfd_pkg::MODE_SPECIAL;
	assign func       = rx_q[sfd_pkg::FUNC_LSB+sfd_pkg::FUNC_W-1:sfd_pkg::FUNC_LSB];
	assign opnd       = rx_q[sfd_pkg::OPND_W-1:0];

	// one-hot strobe for each function; nop and reserved codes strobe nothing
	function automatic logic hit(input logic [5:0] code);
		hit = word_valid && special && (func == code);
	endfunction : hit

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// bits 4 and 3 of the operand are dropped: read-only flag and reserved
	// overtemperature is read live, so no stored flag can race a clear
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			input_select_b_q      <= sfd_pkg::CTL_RESET;
			thermal_shutdown_en_q <= sfd_pkg::CTL_RESET;
			power_down_q          <= sfd_pkg::CTL_RESET;
		end
		else if (hit(sfd_pkg::FN_CONTROL))
		begin
			input_select_b_q      <= opnd[sfd_pkg::CTL_SEL_B_BIT];
			thermal_shutdown_en_q <= opnd[sfd_pkg::CTL_TSD_BIT];
			power_down_q          <= opnd[sfd_pkg::CTL_PD_BIT];
		end
	end

	// ------------------------------------------------------------
	// offset levels
	// ------------------------------------------------------------
	// upper two operand bits are discarded
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			offset_level_zero_q <= sfd_pkg::OFS_RESET;
			offset_level_one_q  <= sfd_pkg::OFS_RESET;
		end
		else
		begin
			if (hit(sfd_pkg::FN_OFS_ZERO))
				offset_level_zero_q <= opnd[sfd_pkg::OFS_W-1:0];
			if (hit(sfd_pkg::FN_OFS_ONE))
				offset_level_one_q <= opnd[sfd_pkg::OFS_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// bank selection registers
	// ------------------------------------------------------------
	// one register per eight channels; bit set routes channel to register b
	for (genvar g = 0; g < sfd_pkg::BANK_COUNT; g++)
	begin : g_bank
		always_ff @(posedge sys_clk or negedge rstn)
		begin
			if (!rstn)
				channel_uses_b_q[g*sfd_pkg::BANK_W +: sfd_pkg::BANK_W] <= sfd_pkg::BANK_RESET;
			else if (hit(sfd_pkg::FN_BANK_0 + 6'(g)) || hit(sfd_pkg::FN_BANK_ALL))
				channel_uses_b_q[g*sfd_pkg::BANK_W +: sfd_pkg::BANK_W] <=
					opnd[sfd_pkg::BANK_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// readback selection
	// ------------------------------------------------------------
	logic [5:0] rb_code_q;
	logic       rb_pending_q;
	logic       rb_sel;
	logic       chan_ok;

	assign rb_sel  = hit(sfd_pkg::FN_READ_SEL);
	// operand bits 6..0 never take part in the decode
	// out-of-range codes read zero instead of aliasing onto a real channel
	assign chan_ok = opnd[sfd_pkg::RB_KIND_LSB+2] == 1'b0
	                 && opnd[sfd_pkg::RB_KIND_LSB-1:sfd_pkg::RB_CODE_LSB] >= sfd_pkg::RB_CHAN_FIRST
	                 && opnd[sfd_pkg::RB_KIND_LSB-1:sfd_pkg::RB_CODE_LSB] <= sfd_pkg::RB_CHAN_LAST;

	// latch kind and code; channel index handed to the channel store
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			readback_kind_q          <= 3'h0;
			rb_code_q                <= 6'h00;
			readback_channel_q       <= 6'h00;
			readback_channel_valid_q <= 1'b0;
		end
		else if (rb_sel)
		begin
			readback_kind_q          <= opnd[sfd_pkg::RB_KIND_LSB+2:sfd_pkg::RB_KIND_LSB];
			rb_code_q                <= opnd[sfd_pkg::RB_KIND_LSB-1:sfd_pkg::RB_CODE_LSB];
			readback_channel_valid_q <= chan_ok;
			readback_channel_q       <= opnd[sfd_pkg::RB_KIND_LSB-1:sfd_pkg::RB_CODE_LSB]
			                            - sfd_pkg::RB_CHAN_FIRST;
		end
	end

	// data chosen for the next transfer; unmapped codes read zero
	logic [15:0] rb_data;
	always_comb
	begin
		rb_data = 16'h0000;
		if (readback_kind_q == sfd_pkg::RB_KIND_GLOBAL)
		begin
			if (rb_code_q == sfd_pkg::RB_CONTROL)
			begin
				rb_data[sfd_pkg::CTL_OT_BIT]    = ot_q;
				rb_data[sfd_pkg::CTL_SEL_B_BIT] = input_select_b_q;
				rb_data[sfd_pkg::CTL_TSD_BIT]   = thermal_shutdown_en_q;
				rb_data[sfd_pkg::CTL_PD_BIT]    = power_down_q;
			end
			else if (rb_code_q == sfd_pkg::RB_OFS_ZERO)
				rb_data = {2'h0, offset_level_zero_q};
			else if (rb_code_q == sfd_pkg::RB_OFS_ONE)
				rb_data = {2'h0, offset_level_one_q};
			else
				for (int i = 0; i < sfd_pkg::BANK_COUNT; i++)
					if (rb_code_q == sfd_pkg::RB_BANK_0 + 6'(i))
						rb_data = {8'h00, channel_uses_b_q[i*sfd_pkg::BANK_W +: sfd_pkg::BANK_W]};
		end
		else if (!readback_kind_q[2] && readback_channel_valid_q)
			rb_data = channel_read_data;
	end

	// ------------------------------------------------------------
	// readback shifter
	// ------------------------------------------------------------
	logic [sfd_pkg::WORD_BITS-1:0] tx_q;
	logic                          tx_active_q;

	// output enabled at select, loaded at next frame start, changed on rising
	// clock so the host samples a settled bit on the falling edge
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rb_pending_q          <= 1'b0;
			tx_active_q           <= 1'b0;
			tx_q                  <= '0;
			serial_data_output    <= 1'b0;
			serial_data_output_oe <= 1'b0;
		end
		else if (frame_end)
		begin
			// a new select in the closing frame re-arms the output at once
			tx_active_q           <= 1'b0;
			rb_pending_q          <= rb_sel;
			serial_data_output_oe <= rb_sel || rb_pending_q;
			// pin back to zero at every frame end, so a later frame opens on zero
			serial_data_output    <= 1'b0;
		end
		else if (frame_start && rb_pending_q)
		begin
			rb_pending_q       <= 1'b0;
			tx_active_q        <= 1'b1;
			tx_q               <= {8'h00, rb_data} << 1;
			serial_data_output <= 1'b0; // word's top bit, always zero
		end
		else if (tx_active_q && !sync_q && sclk_rise)
		begin
			serial_data_output <= tx_q[sfd_pkg::WORD_BITS-1];
			tx_q               <= tx_q << 1;
		end
	end

endmodule : serial_special_function_decoder

// ---- dv/sfd_asserts.sv ----
// port checker for the special-function decoder
// assumes link pins are slow against sys_clk, frames >=8 clocks apart
module sfd_asserts (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	// link pins
	input wire logic        frame_sync_n,
	input wire logic        serial_data_output,
	input wire logic        serial_data_output_oe,
	// decoded state
	input wire logic [2:0]  readback_kind_q,
	input wire logic [5:0]  readback_channel_q,
	input wire logic        readback_channel_valid_q,
	input wire logic        input_select_b_q,
	input wire logic        thermal_shutdown_en_q,
	input wire logic        power_down_q,
	input wire logic [13:0] offset_level_zero_q,
	input wire logic [39:0] channel_uses_b_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_frame_open;
		$fell(frame_sync_n) && serial_data_output_oe;
	endsequence
	sequence s_lead_zero;
		!serial_data_output [*8];
	endsequence
	property p_lead_zero;
		s_frame_open |-> s_lead_zero;
	endproperty
	property p_oe_holds;
		serial_data_output_oe && !frame_sync_n |=> serial_data_output_oe;
	endproperty
	property p_oe_rise;
		$rose(serial_data_output_oe) |-> frame_sync_n && $past(frame_sync_n, 2);
	endproperty
	property p_oe_fall;
		$fell(serial_data_output_oe) |-> frame_sync_n && $past(frame_sync_n, 2);
	endproperty
	// control fields move only once a frame has closed
	property p_ctl_apply;
		$changed({input_select_b_q, thermal_shutdown_en_q, power_down_q})
			|-> frame_sync_n && $past(frame_sync_n, 2);
	endproperty
	property p_bank_apply;
		$changed(channel_uses_b_q) |-> $past(frame_sync_n, 2);
	endproperty
	// a gap of 8 clocks or more cannot hide in 6, so no apply is pending
	property p_hold_in_frame;
		!frame_sync_n && !$past(frame_sync_n, 6) |-> $stable(offset_level_zero_q);
	endproperty
	property p_valid;
		readback_channel_valid_q |-> readback_kind_q < 3'h4 && readback_channel_q <= 6'h27;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("readback lead bits not zero");
	a_oe_holds: assert property (p_oe_holds) else $error("output enable dropped in frame");
	a_oe_rise: assert property (p_oe_rise) else $error("output enable rose in frame");
	a_oe_fall: assert property (p_oe_fall) else $error("output enable fell in frame");
	a_ctl_apply: assert property (p_ctl_apply) else $error("control moved in frame");
	a_bank_apply: assert property (p_bank_apply) else $error("bank moved in frame");
	a_hold_in_frame: assert property (p_hold_in_frame) else $error("offset moved in frame");
	a_valid: assert property (p_valid) else $error("channel valid out of range");
endmodule : sfd_asserts

bind serial_special_function_decoder sfd_asserts sfd_asserts_inst (.sys_clk, .rstn,
	.frame_sync_n, .serial_data_output, .serial_data_output_oe, .readback_kind_q,
	.readback_channel_q, .readback_channel_valid_q, .input_select_b_q,
	.thermal_shutdown_en_q, .power_down_q, .offset_level_zero_q, .channel_uses_b_q);

// ---- dv/spi_host_model.sv ----
// serial bus master model: 400 ns link clock, idle high between frames
// assumes the data pin is only meaningful while its enable is high
module spi_host_model (
	// link pins
	output logic      serial_clock,
	output logic      frame_sync_n,
	output logic      serial_data_input,
	input  wire logic serial_data_output,
	input  wire logic serial_data_output_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		serial_clock = 1'b1;
		frame_sync_n = 1'b1;
		serial_data_input = 1'b0;
	end
	// one frame of falls edges; rd sampled at each of the first 24 falls, msb first
	task automatic xfer(input logic [23:0] w, input int falls, output logic [23:0] rd);
		int i;
		rd = 24'h000000;
		frame_sync_n <= 1'b0;
		#200;
		for (i = 0; i < falls; i++)
		begin
			serial_data_input <= (i < 24) ? w[23-i] : ~serial_data_input;
			#200 serial_clock <= 1'b0;
			if (i < 24)
				rd[23-i] = serial_data_output_oe ? serial_data_output : 1'bz;
			#200 serial_clock <= 1'b1;
		end
		frame_sync_n <= 1'b1;
		serial_data_input <= ~serial_data_input; // released line must not look held
		#400;
	endtask : xfer
endmodule : spi_host_model

// ---- dv/tb_serial_special_function_decoder.sv ----
// table-driven bench for the special-function decoder
// assumes the host model in spi_host_model and the bound checker
module tb_serial_special_function_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [23:0] cmd; logic [15:0] sel; logic [15:0] val;} row_s;
	logic sys_clk = 1'b0, rstn = 1'b0, overtemp_alarm = 1'b0;
	logic [15:0] channel_read_data = 16'hc3a5;
	wire logic serial_clock, frame_sync_n, serial_data_input;
	wire logic serial_data_output, serial_data_output_oe, readback_channel_valid_q;
	wire logic input_select_b_q, thermal_shutdown_en_q, power_down_q;
	wire logic [2:0] readback_kind_q;
	wire logic [5:0] readback_channel_q;
	wire logic [13:0] offset_level_zero_q, offset_level_one_q;
	wire logic [39:0] channel_uses_b_q;
	logic [2:0] e_ctl;
	logic [13:0] e_o0, e_o1;
	logic [39:0] e_bk;
	logic [23:0] rd;
	int fail_count = 0, total_checks = 0;
	row_s rows [19] = '{
		'{24'h010007, 16'h8080, 16'h0007},
		'{24'h010002, 16'h8080, 16'h0002},
		'{24'h02ffff, 16'h8100, 16'h3fff},
		'{24'h03d555, 16'h8180, 16'h1555},
		'{24'h06ab5a, 16'h8300, 16'h005a},
		'{24'h07ff81, 16'h0000, 16'h0000},
		'{24'h0800c3, 16'h0000, 16'h0000},
		'{24'h09ee24, 16'h0000, 16'h0000},
		'{24'h0aff3c, 16'h8500, 16'h003c},
		'{24'h0b00ff, 16'h8400, 16'h00ff},
		'{24'h0b0000, 16'h8480, 16'h0000},
		'{24'hc10007, 16'h0000, 16'h0000},
		'{24'h000000, 16'h0000, 16'h0000},
		'{24'h04ffff, 16'h0000, 16'h0000},
		'{24'h3c1234, 16'h8200, 16'h0000},
		'{24'h000000, 16'h047f, 16'hc3a5},
		'{24'h000000, 16'h7780, 16'hc3a5},
		'{24'h000000, 16'h3f80, 16'h0000},
		'{24'h000000, 16'h8580, 16'h0000}};
	// ------------------------------------------------------------
	// clock, design, host
	// ------------------------------------------------------------
	always #25 sys_clk = ~sys_clk;
	serial_special_function_decoder serial_special_function_decoder_inst (.sys_clk, .rstn,
		.serial_clock, .frame_sync_n, .serial_data_input, .serial_data_output,
		.serial_data_output_oe, .overtemp_alarm, .channel_read_data, .readback_kind_q,
		.readback_channel_q, .readback_channel_valid_q, .input_select_b_q,
		.thermal_shutdown_en_q, .power_down_q, .offset_level_zero_q, .offset_level_one_q,
		.channel_uses_b_q);
	spi_host_model spi_host_model_inst (.serial_clock, .frame_sync_n, .serial_data_input,
		.serial_data_output, .serial_data_output_oe);
	// ------------------------------------------------------------
	// checks and sequences
	// ------------------------------------------------------------
	task automatic chk_st(input logic oe, input string nm);
		logic [71:0] e, g;
		e = {oe, e_ctl, e_o0, e_o1, e_bk};
		g = {serial_data_output_oe, input_select_b_q, thermal_shutdown_en_q, power_down_q,
			offset_level_zero_q, offset_level_one_q, channel_uses_b_q};
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk_st
	task automatic chk_rd(input logic [23:0] e, input string nm);
		total_checks++;
		if (rd !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, rd);
		end
	endtask : chk_rd
	// readback select outputs: kind, channel index and its validity
	task automatic chk_sel(input logic [15:0] s, input string nm);
		logic [9:0] e, g;
		logic [5:0] c;
		c = s[sfd_pkg::RB_KIND_LSB-1:sfd_pkg::RB_CODE_LSB];
		e = {s[15:13], 6'(c - sfd_pkg::RB_CHAN_FIRST),
			!s[15] && c >= sfd_pkg::RB_CHAN_FIRST && c <= sfd_pkg::RB_CHAN_LAST};
		g = {readback_kind_q, readback_channel_q, readback_channel_valid_q};
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk_sel
	// expected state follows the function code of a whole word
	task automatic apply(input logic [23:0] w);
		int ix;
		ix = int'(w[21:16]) - int'(sfd_pkg::FN_BANK_0);
		if (w[23:22] === sfd_pkg::MODE_SPECIAL)
			case (w[21:16])
				sfd_pkg::FN_CONTROL: e_ctl = w[2:0];
				sfd_pkg::FN_OFS_ZERO: e_o0 = w[13:0];
				sfd_pkg::FN_OFS_ONE: e_o1 = w[13:0];
				sfd_pkg::FN_BANK_ALL: e_bk = {5{w[7:0]}};
				default: if (ix >= 0 && ix < 5) e_bk[8*ix +: 8] = w[7:0];
			endcase
	endtask : apply
	task automatic run(input row_s r);
		spi_host_model_inst.xfer(r.cmd, 24, rd);
		apply(r.cmd);
		chk_st(1'b0, "state");
		if (r.sel !== 16'h0000)
		begin
			spi_host_model_inst.xfer({2'b00, sfd_pkg::FN_READ_SEL, r.sel}, 24, rd);
			chk_sel(r.sel, "select");
			spi_host_model_inst.xfer(24'h000000, 24, rd);
			chk_rd({8'h00, r.val}, "readback");
		end
	endtask : run
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end
	initial
	begin
		{e_ctl, e_o0, e_o1, e_bk} = '0;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk_st(1'b0, "reset state");
		foreach (rows[i])
		begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		// short and overlong frames are dropped whole
		spi_host_model_inst.xfer(24'h020123, 23, rd);
		chk_st(1'b0, "short frame");
		spi_host_model_inst.xfer(24'h030456, 25, rd);
		chk_st(1'b0, "long frame");
		$display("frame length test done");
		// live flag shows in bit 4 of the control readback
		@(posedge sys_clk) overtemp_alarm <= 1'b1;
		run('{24'h000000, 16'h8080, 16'h0012});
		$display("overtemp test done");
		// a select inside the readback frame keeps the pin driven
		spi_host_model_inst.xfer({2'b00, sfd_pkg::FN_READ_SEL, 16'h8100}, 24, rd);
		chk_st(1'b1, "enable after select");
		spi_host_model_inst.xfer({2'b00, sfd_pkg::FN_READ_SEL, 16'h8180}, 24, rd);
		chk_rd({10'h000, e_o0}, "first readback");
		chk_st(1'b1, "enable kept");
		spi_host_model_inst.xfer(24'h000000, 24, rd);
		chk_rd({10'h000, e_o1}, "second readback");
		chk_st(1'b0, "enable released");
		$display("back to back readback done");
		// reset in mid-run clears everything again
		@(posedge sys_clk) rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		{e_ctl, e_o0, e_o1, e_bk} = '0;
		repeat (3) @(posedge sys_clk);
		chk_st(1'b0, "second reset");
		run('{24'h0b0081, 16'h8380, 16'h0081});
		$display("second reset test done");
		conclude();
	end
endmodule : tb_serial_special_function_decoder
